// ===== pdcc_map.svh
// register offsets, field positions, reset values for the device capability/control pair
// assumes inclusion from the package and the modules by bare name
`ifndef PDCC_MAP_SVH
`define PDCC_MAP_SVH
`define PDCC_OFF_DEVCAP      8'hc4
`define PDCC_OFF_DEVCTL      8'hc8
`define PDCC_MPS_128         3'h0
`define PDCC_MPS_256         3'h1
`define PDCC_MPS_512         3'h2
`define PDCC_CAP_MPS_LSB     0
`define PDCC_CAP_RBER_BIT    15
`define PDCC_CAP_SPLV_LSB    18
`define PDCC_CAP_SPLS_LSB    26
`define PDCC_CTL_CERE_BIT    0
`define PDCC_CTL_NFERE_BIT   1
`define PDCC_CTL_FERE_BIT    2
`define PDCC_CTL_URRE_BIT    3
`define PDCC_CTL_MPS_LSB     5
`define PDCC_CTL_AUXPM_BIT   10
`define PDCC_STS_ERR_LSB     16
`define PDCC_RST_RBER        1'h1
`define PDCC_RST_SPLV        8'h00
`define PDCC_RST_SPLS        2'h0
`define PDCC_RST_ERRE        4'h0
`define PDCC_RST_AUXPM       1'h0
`endif

// ===== pdcc_pkg.sv
// types shared by the capability/control register bank
// assumes pdcc_map.svh is on the include path
`include "pdcc_map.svh"
package pdcc_pkg;
  typedef logic [2:0] pdcc_mps_t;
  // one error class per bit: ur, fatal, nonfatal, correctable
  typedef struct packed {
    logic ur;
    logic fatal;
    logic nonfatal;
    logic corr;
  } pdcc_err_s;
  typedef struct packed {
    logic       valid;
    logic [1:0] scale;
    logic [7:0] value;
  } pdcc_spl_s;
  typedef struct packed {
    logic       valid;
    pdcc_mps_t  mps;
    logic       rber;
  } pdcc_load_s;
endpackage : pdcc_pkg

// ===== pdcc_err_flags.sv
// sticky detected-error flags with write-one-to-clear and gated message requests
// assumes all inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pdcc_err_flags
  import pdcc_pkg::*;
(
  input  wire logic      clk,       // core clock
  input  wire logic      rstSyncN,  // synchronised reset, low active
  input  wire pdcc_err_s errEvent,  // one-cycle error pulses
  input  wire pdcc_err_s errClear,  // write-one-to-clear strobes
  input  wire pdcc_err_s errEnable, // reporting enables
  output pdcc_err_s      errFlags,  // sticky detected flags
  output pdcc_err_s      errMsg     // message request pulses
);
  // R16 log regardless of enable; set beats clear
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      errFlags <= '0;
    end else begin
      errFlags <= (errFlags & ~errClear) | errEvent;
    end
  end

  // R17 message only when enabled
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      errMsg <= '0;
    end else begin
      errMsg <= errEvent & errEnable;
    end
  end
endmodule : pdcc_err_flags
`default_nettype wire

// ===== pdcc_regs.sv
// device capability and device control/status registers of one switch port
// assumes a simple synchronous config port: one-cycle wr/rd strobes, read data next cycle
`timescale 1ns/1ps
`default_nettype none
`include "pdcc_map.svh"
// What this block does
// R1 - supported payload codes: 0 is 128, 1 is 256, 2 is 512 bytes
// R2 - strap low loads 256-byte code, high loads 512-byte code at reset
// R3 - serial bus or eeprom load replaces payload and role-based defaults
// R4 - phantom function support bits 4:3 read zero
// R5 - extended tag support bit 5 reads zero
// R6 - endpoint latency fields 8:6 and 11:9 read zero
// R7 - role-based error reporting bit 15 resets to one
// R8 - upstream port captures slot power limit value into bits 25:18
// R9 - upstream port captures slot power limit scale into bits 27:26
// R10 - control bits 3:0 are error reporting enables, reset disabled
// R11 - relaxed ordering bit 4 reads zero
// R12 - control bits 7:5 hold programmed payload size, reset 128 bytes
// R13 - writes above supported payload store the supported value
// R14 - extended tag and phantom enables read zero always
// R15 - control bit 10 is aux power enable, reset zero
// R16 - detected error flags set whatever the enables are
// R17 - error messages sent only for enabled classes
module pdcc_regs
  import pdcc_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1  // port role
)(
  input  wire logic        core_clk,        // 40 MHz core clock
  input  wire logic        rstn,            // async reset, low active
  input  wire logic        payload_512_strap, // strap pin
  input  wire pdcc_load_s  defaultLoad,     // serial bus / eeprom default load
  input  wire pdcc_spl_s   slotPowerMsg,    // received slot power limit message
  input  wire pdcc_err_s   errEvent,        // error detect pulses
  input  wire logic        cfgWr,           // config write strobe
  input  wire logic        cfgRd,           // config read strobe
  input  wire logic [7:0]  cfgAddr,         // config byte address
  input  wire logic [3:0]  cfgBe,           // byte enables
  input  wire logic [31:0] cfgWdata,        // write data
  output logic      [31:0] cfgRdata,        // read data
  output logic             cfgRdValid,      // read data valid
  output pdcc_err_s        errMsg,          // error message requests
  output pdcc_mps_t        maxPayload,      // programmed payload size
  output logic             auxPowerEn       // aux power enable
);

  // ****************************************
  // reset and strap synchronisers
  // ****************************************
  logic [1:0] rstPipe;
  logic       rstSyncN;
  logic       strapMeta;
  logic       strapSync;
  logic       strapTaken;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // strap pipe released with the raw reset, so it already holds
  // the pin level when the rest of the bank leaves reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strapMeta <= 1'b0;
      strapSync <= 1'b0;
    end else begin
      strapMeta <= payload_512_strap;
      strapSync <= strapMeta;
    end
  end

  // ****************************************
  // capability fields
  // ****************************************
  pdcc_mps_t  mpsSupported;
  logic       rberCap;
  logic [7:0] splValue;
  logic [1:0] splScale;

  // R2 strap caught once after release
  // R3 default load overrides strap value
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      strapTaken   <= 1'b0;
      mpsSupported <= `PDCC_MPS_256;
      rberCap      <= `PDCC_RST_RBER;
    end else begin
      strapTaken <= 1'b1;
      if (defaultLoad.valid) begin
        mpsSupported <= defaultLoad.mps;
        rberCap      <= defaultLoad.rber;
      end else if (!strapTaken) begin
        mpsSupported <= strapSync ? `PDCC_MPS_512 : `PDCC_MPS_256;
      end
    end
  end

  // R8 capture slot power value
  // R9 capture slot power scale
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      splValue <= `PDCC_RST_SPLV;
      splScale <= `PDCC_RST_SPLS;
    end else if (IS_UPSTREAM && slotPowerMsg.valid) begin
      splValue <= slotPowerMsg.value;
      splScale <= slotPowerMsg.scale;
    end
  end

  // ****************************************
  // control fields
  // ****************************************
  logic       wrCap;
  logic       wrCtl;
  pdcc_err_s  errEnable;
  pdcc_err_s  errClear;
  pdcc_err_s  errFlags;
  pdcc_mps_t  next_maxPayload;
  pdcc_mps_t  writtenMps;

  assign wrCap      = cfgWr && (cfgAddr == `PDCC_OFF_DEVCAP);
  assign wrCtl      = cfgWr && (cfgAddr == `PDCC_OFF_DEVCTL);
  assign writtenMps = cfgWdata[`PDCC_CTL_MPS_LSB +: 3];

  // R13 clamp to supported size
  always_comb begin
    next_maxPayload = maxPayload;
    if (wrCtl && cfgBe[0]) begin
      next_maxPayload = (writtenMps > mpsSupported) ? mpsSupported : writtenMps;
    end
  end

  // R10 error reporting enables
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      errEnable <= `PDCC_RST_ERRE;
    end else if (wrCtl && cfgBe[0]) begin
      errEnable <= cfgWdata[`PDCC_CTL_URRE_BIT:`PDCC_CTL_CERE_BIT];
    end
  end

  // R12 programmed payload field
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      maxPayload <= `PDCC_MPS_128;
    end else begin
      maxPayload <= next_maxPayload;
    end
  end

  // R15 aux power enable
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      auxPowerEn <= `PDCC_RST_AUXPM;
    end else if (wrCtl && cfgBe[1]) begin
      auxPowerEn <= cfgWdata[`PDCC_CTL_AUXPM_BIT];
    end
  end

  // status flags live in the upper half of the control word
  assign errClear = (wrCtl && cfgBe[2]) ? pdcc_err_s'(cfgWdata[`PDCC_STS_ERR_LSB +: 4]) : pdcc_err_s'(4'h0);

  pdcc_err_flags u_err_flags (
    .clk       (core_clk),
    .rstSyncN  (rstSyncN),
    .errEvent  (errEvent),
    .errClear  (errClear),
    .errEnable (errEnable),
    .errFlags  (errFlags),
    .errMsg    (errMsg)
  );

  // ****************************************
  // read path
  // ****************************************
  logic [31:0] capWord;
  logic [31:0] ctlWord;

  // R1 payload code in bits 2:0
  // R4 phantom bits stay zero
  // R5 extended tag bit stays zero
  // R6 latency fields stay zero
  // R7 role-based bit from its register
  always_comb begin
    capWord = 32'h0;
    capWord[`PDCC_CAP_MPS_LSB +: 3] = mpsSupported;
    capWord[`PDCC_CAP_RBER_BIT]     = rberCap;
    capWord[`PDCC_CAP_SPLV_LSB +: 8] = splValue;
    capWord[`PDCC_CAP_SPLS_LSB +: 2] = splScale;
  end

  // R11 relaxed ordering reads zero
  // R14 tag and phantom enables read zero
  always_comb begin
    ctlWord = 32'h0;
    ctlWord[`PDCC_CTL_URRE_BIT:`PDCC_CTL_CERE_BIT] = errEnable;
    ctlWord[`PDCC_CTL_MPS_LSB +: 3]  = maxPayload;
    ctlWord[`PDCC_CTL_AUXPM_BIT]     = auxPowerEn;
    ctlWord[`PDCC_STS_ERR_LSB +: 4]  = errFlags;
  end

  // capability writes are accepted and dropped: all fields are read-only
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgRdata   <= 32'h0;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRd;
      if (cfgRd) begin
        case (cfgAddr)
          `PDCC_OFF_DEVCAP: cfgRdata <= capWord;
          `PDCC_OFF_DEVCTL: cfgRdata <= ctlWord;
          default:          cfgRdata <= 32'h0;
        endcase
      end
    end
  end

  logic unusedWrCap;
  assign unusedWrCap = wrCap;

endmodule : pdcc_regs
`default_nettype wire

// ===== pdcc_regs_chk.sv
// assertions on the ports of the capability/control bank
// assumes one clock, bound onto every pdcc_regs instance
`timescale 1ns/1ps
`default_nettype none
module pdcc_regs_chk
  import pdcc_pkg::*;
(
  input wire logic        core_clk,   // clock
  input wire logic        rstn,       // reset, low active
  input wire pdcc_err_s   errEvent,   // error pulses
  input wire logic        cfgWr,      // write strobe
  input wire logic [7:0]  cfgAddr,    // address
  input wire logic [3:0]  cfgBe,      // byte enables
  input wire logic [31:0] cfgWdata,   // write data
  input wire logic [31:0] cfgRdata,   // read data
  input wire logic        cfgRdValid, // read valid
  input wire pdcc_err_s   errMsg,     // message pulses
  input wire pdcc_mps_t   maxPayload, // payload code
  input wire logic        auxPowerEn  // aux enable
);
  // ****************************************
  // properties
  // ****************************************
  logic wrCtl;
  assign wrCtl = cfgWr && cfgAddr == 8'hc8;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_capzero; cfgRdValid && $past(cfgAddr) == 8'hc4 |-> cfgRdata[14:3] == 12'h0; endproperty
  a_capzero: assert property (p_capzero) else $error("capability zero bits set");
  property p_ctlzero; cfgRdValid && $past(cfgAddr) == 8'hc8 |-> {cfgRdata[9:8], cfgRdata[4]} == 3'h0; endproperty
  a_ctlzero: assert property (p_ctlzero) else $error("control zero bits set");
  property p_mpsrd; cfgRdValid && $past(cfgAddr) == 8'hc8 |-> cfgRdata[7:5] == maxPayload; endproperty
  a_mpsrd: assert property (p_mpsrd) else $error("payload field differs from output");
  property p_auxrd; cfgRdValid && $past(cfgAddr) == 8'hc8 |-> cfgRdata[10] == auxPowerEn; endproperty
  a_auxrd: assert property (p_auxrd) else $error("aux bit differs from output");
  property p_auxwr; wrCtl && cfgBe[1] |=> auxPowerEn == $past(cfgWdata[10]); endproperty
  a_auxwr: assert property (p_auxwr) else $error("aux enable not written");
  property p_mpswr; wrCtl && cfgBe[0] |=> maxPayload <= $past(cfgWdata[7:5]); endproperty
  a_mpswr: assert property (p_mpswr) else $error("payload above written code");
  property p_mpsmax; maxPayload <= 3'h2; endproperty
  a_mpsmax: assert property (p_mpsmax) else $error("payload code reserved");
  property p_msg; errMsg != 4'h0 |-> (errMsg & ~$past(errEvent)) == 4'h0; endproperty
  a_msg: assert property (p_msg) else $error("message without error");
  c_msg: cover property (errMsg != 4'h0);
  c_wr: cover property (wrCtl && cfgBe[0]);
  c_rd: cover property (cfgRdValid && $past(cfgAddr) == 8'hc4);
endmodule : pdcc_regs_chk
bind pdcc_regs pdcc_regs_chk pdcc_regs_chk_i (.*);
`default_nettype wire

// ===== pdcc_far_end.sv
// upstream partner that sends slot power limit messages
// assumes go is a one-cycle pulse from the bench
`timescale 1ns/1ps
`default_nettype none
module pdcc_far_end
  import pdcc_pkg::*;
(
  input  wire logic       core_clk,     // clock
  input  wire logic       go,           // send one message
  input  wire logic [9:0] pay,          // scale and value
  output pdcc_spl_s       slotPowerMsg  // message to the port
);
  // ****************************************
  // message sender
  // ****************************************
  // idle payload toggles so stale fields are never trusted
  always_ff @(posedge core_clk) begin
    slotPowerMsg <= go ? {1'b1, pay} : {1'b0, ~slotPowerMsg[9:0]};
  end
endmodule : pdcc_far_end
`default_nettype wire

// ===== pdcc_regs_tb_top.sv
// self-checking bench for the capability/control bank
// assumes the checker is bound and the partner sends messages
`timescale 1ns/1ps
`default_nettype none
module pdcc_regs_tb_top;
  import pdcc_pkg::*;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic core_clk, rstn, strap, cfgWr, cfgRd, cfgRdValid, auxPowerEn, spGo;
  logic [7:0] cfgAddr;
  logic [3:0] cfgBe;
  logic [31:0] cfgWdata, cfgRdata;
  pdcc_load_s dLoad;
  pdcc_spl_s spMsg;
  pdcc_err_s errEvent, errMsg;
  pdcc_mps_t maxPayload;
  int nMismatch, nTests;
  always #12.5 core_clk = ~core_clk;
  pdcc_regs pdcc_regs_i (.core_clk(core_clk), .rstn(rstn), .payload_512_strap(strap), .defaultLoad(dLoad),
    .slotPowerMsg(spMsg), .errEvent(errEvent), .cfgWr(cfgWr), .cfgRd(cfgRd), .cfgAddr(cfgAddr), .cfgBe(cfgBe),
    .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid), .errMsg(errMsg),
    .maxPayload(maxPayload), .auxPowerEn(auxPowerEn));
  pdcc_far_end pdcc_far_end_i (.core_clk(core_clk), .go(spGo), .pay(10'h3a5), .slotPowerMsg(spMsg));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      nMismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge core_clk) {cfgWr, cfgAddr, cfgBe, cfgWdata} <= {1'b1, a, b, d};
    @(posedge core_clk) cfgWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk) {cfgRd, cfgAddr} <= {1'b1, a};
    @(posedge core_clk) cfgRd <= 1'b0;
    #1 chk(32'(cfgRdValid), 32'h1);
    chk(cfgRdata, e);
  endtask : rd
  task automatic ev(input pdcc_err_s e, input pdcc_err_s m);
    @(posedge core_clk) errEvent <= e;
    @(posedge core_clk) errEvent <= 4'h0;
    #1 chk(32'(errMsg), 32'(m));
  endtask : ev
  task automatic do_reset(input logic s);
    rstn <= 1'b0;
    strap <= s;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : do_reset
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    {core_clk, rstn, strap, cfgWr, cfgRd, spGo, cfgAddr, cfgBe, cfgWdata, dLoad, errEvent} = '0;
    do_reset(1'b0);
    rd(8'hc4, 32'h0000_8001);
    rd(8'hc8, 32'h0);
    wr(8'hc8, 4'h3, 32'h0000_ffff);
    rd(8'hc8, 32'h0000_042f);
    chk(32'(maxPayload), 32'h1);
    chk(32'(auxPowerEn), 32'h1);
    for (int i = 0; i < 4; i++) ev(4'h1 << i, 4'h1 << i);
    rd(8'hc8, 32'h000f_042f);
    wr(8'hc8, 4'h7, 32'h000f_0000);
    rd(8'hc8, 32'h0);
    ev(4'hf, 4'h0);
    rd(8'hc8, 32'h000f_0000);
    @(posedge core_clk) spGo <= 1'b1;
    @(posedge core_clk) spGo <= 1'b0;
    rd(8'hc4, 32'h0e94_8001);
    wr(8'hc4, 4'hf, 32'hffff_ffff);
    rd(8'hc4, 32'h0e94_8001);
    @(posedge core_clk) dLoad <= 5'b1_010_0;
    @(posedge core_clk) dLoad <= 5'h0;
    rd(8'hc4, 32'h0e94_0002);
    wr(8'hc8, 4'h1, 32'h0000_00e0);
    chk(32'(maxPayload), 32'h2);
    wr(8'hc8, 4'h1, 32'h0000_0060);
    chk(32'(maxPayload), 32'h2);
    rd(8'hc0, 32'h0);
    do_reset(1'b1);
    rd(8'hc4, 32'h0000_8002);
    rd(8'hc8, 32'h0);
    final_report();
  end
  initial begin
    #20000;
    nMismatch++;
    final_report();
  end
endmodule : pdcc_regs_tb_top
`default_nettype wire
